// ==== design/rsts_pkg.sv ====
`default_nettype none
package rsts_pkg;
  // Sensor timing, in sensor clocks and rows
  localparam int ROW_CLKS      = 2624;
  localparam int FULL_ROWS     = 1080;
  localparam int TRIG_MIN_CLKS = 2;
  localparam int FIRE_LOW_MIN  = 20;
  localparam logic [4:0] FIRE_LOW_CLKS = 5'h14;
  localparam int ROI_W = 12;

  // Register offsets (byte addresses)
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_EXP    = 8'h04;
  localparam logic [7:0] A_ROI    = 8'h08;
  localparam logic [7:0] A_SWTRIG = 8'h0C;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_FCNT   = 8'h14;

  // Field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MODE = 1;
  localparam int SWTRIG_GO = 0;

  // Reset values; exposure is held in half rows
  localparam logic [31:0] EXP_RST = 32'h0000_0872;
  localparam logic [11:0] ROI_RST = 12'h438;

  typedef enum logic [1:0] {
    MODE_EXT_SW, MODE_EXT_EXP, MODE_EXT_OVL, MODE_EXT_START
  } rsts_mode_e;

  typedef struct packed {
    logic global_clear;
    logic readout;
    logic discard;
  } rsts_sensor_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rsts_bus_s;
endpackage
`default_nettype wire

// ==== design/rsts_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsts_readout #(
  parameter int ROW_CLKS = rsts_pkg::ROW_CLKS,
  parameter int RW       = rsts_pkg::ROI_W
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          start,
  input  wire logic [RW-1:0] frame_rows,
  output logic               busy,
  output logic               row_tick,
  output logic               done
);
  localparam int CW = $clog2(ROW_CLKS);

  logic [CW-1:0] clk_q;
  logic [RW-1:0] row_q;
  logic          busy_q;
  logic [31:0]   gap_q;

  // Row clock runs free so exposure can be timed between readouts
  assign row_tick = (clk_q == CW'(ROW_CLKS - 1));
  assign done     = busy_q & row_tick & (row_q == frame_rows - RW'(1));
  assign busy     = busy_q;

  // Start realigns the row clock, which keeps trigger jitter in a row
  always_ff @(posedge mclk) begin
    if (sys_rst || start || row_tick) begin
      clk_q <= '0;
    end else begin
      clk_q <= clk_q + CW'(1);
    end
  end

  // One frame is the rows of one sensor half
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      row_q  <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      row_q  <= '0;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q && row_tick) begin
      row_q <= row_q + RW'(1);
    end
  end

  // Helper: wide count, so a missed tick cannot wrap unseen
  always_ff @(posedge mclk) begin
    if (sys_rst || start || row_tick) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  chk_row_period: assert property (@(posedge mclk) disable iff (sys_rst)
    (row_tick && !$past(start)) |-> gap_q == 32'(ROW_CLKS - 1))
    else $error("row period is not the row clock count");
  chk_row_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    gap_q <= 32'(ROW_CLKS - 1))
    else $error("row clock ran past the row length");
endmodule
`default_nettype wire

// ==== design/rsts_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Awaiting trigger: clear held, prescan readouts run
// - Ready output high while trigger detectable
// - Pin or software trigger, same sequence
// - Trigger drops clear, starts discarded flush
// - Signal readout, then clear until trigger
// - Exposure at least frame plus row
// - Two-clock trigger pulses are detected
// - Exposure from setting, start within row
// - Exposure mode: falling edge starts signal
// - Pulse width sets every row's exposure
// - Falls during flush are ignored
// - Overlap: each rising edge reads and exposes
// - Overlap: first edge discards, later signal
// - Overlap exposure indicator low twenty clocks
// - External start: one trigger, then free-run
// - External start delay within one row
// - Exposure rounded to nearest whole row
// - Row lasts 2624 sensor clocks
// - Frame is rows of one sensor half
// - Mode changes only while stopped
// - Clear falling edge starts charge accumulation
module rsts_seq #(
  parameter int ROW_CLKS = rsts_pkg::ROW_CLKS,
  parameter int ROI_W    = rsts_pkg::ROI_W
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire rsts_pkg::rsts_bus_s    reg_req,
  output logic [31:0]                 reg_rdata,
  input  wire logic                   external_trigger_in,
  output rsts_pkg::rsts_sensor_s      sensor,
  output logic                        ready_for_trigger,
  output logic                        exposure_ind
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_FLUSH, ST_EXPOSE, ST_SIGNAL, ST_HOLD, ST_OVL
  } rsts_state_e;

  rsts_state_e          st_q;
  rsts_state_e          st_d;
  rsts_pkg::rsts_mode_e mode_q;
  logic                 en_q;
  logic [31:0]          exp_q;
  logic [ROI_W-1:0]     region_of_interest_q;
  logic [31:0]          exp_rows_q;
  logic [31:0]          exp_cnt_q;
  logic [15:0]          fcnt_q;
  logic [31:0]          rdata_q;
  logic                 trig_m_q;
  logic                 trig_s_q;
  logic                 trig_d_q;
  logic                 gclr_q;
  logic                 discard_q;
  logic                 ready_q;
  logic                 expind_q;
  logic [4:0]           fire_cnt_q;
  logic [7:0]           low_run_q;
  logic                 rise;
  logic                 fall;
  logic                 sw_trig;
  logic                 trig_ok;
  logic                 ro_start;
  logic                 ro_busy;
  logic                 ro_tick;
  logic                 ro_done;
  logic                 exp_hit;
  logic [32:0]          exp_sum;
  logic [31:0]          exp_round;
  logic [31:0]          exp_floor;

  // Pin passes two flops; the third only feeds the edge detector
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_d_q <= 1'b0;
    end else begin
      trig_m_q <= external_trigger_in;
      trig_s_q <= trig_m_q;
      trig_d_q <= trig_s_q;
    end
  end

  // Every clock sampled, so a two-clock pulse always yields an edge
  assign rise = trig_s_q & ~trig_d_q;
  assign fall = ~trig_s_q & trig_d_q;

  // Software trigger is a write of one to its go bit
  assign sw_trig = reg_req.wr && (reg_req.addr == rsts_pkg::A_SWTRIG)
                   && reg_req.wdata[rsts_pkg::SWTRIG_GO];

  // Software trigger only in the shared pin/software mode
  assign trig_ok = rise
                   || (sw_trig && mode_q == rsts_pkg::MODE_EXT_SW);

  // Half-row units plus one, halved: nearest whole row
  assign exp_sum   = {1'b0, exp_q} + 33'h0_0000_0001;
  assign exp_round = exp_sum[32:1];
  assign exp_floor = 32'(region_of_interest_q) + 32'h0000_0001;

  // Exposure counted in rows from the start of the flush
  assign exp_hit = ro_tick && (exp_cnt_q + 32'h0000_0001 == exp_rows_q);

  rsts_readout #(
    .ROW_CLKS (ROW_CLKS),
    .RW       (ROI_W)
  ) u_readout (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .start      (ro_start),
    .frame_rows (region_of_interest_q),
    .busy       (ro_busy),
    .row_tick   (ro_tick),
    .done       (ro_done)
  );

  // Sequencer next state and readout launches
  always_comb begin
    st_d     = st_q;
    ro_start = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (en_q) begin
          st_d     = ST_ARMED;
          ro_start = 1'b1;
        end
      end
      ST_ARMED: begin
        if (trig_ok) begin
          st_d     = ST_FLUSH;
          ro_start = 1'b1;
        end else if (ro_done) begin
          ro_start = 1'b1;
        end
      end
      ST_FLUSH: begin
        if (ro_done) begin
          st_d = (mode_q == rsts_pkg::MODE_EXT_OVL) ? ST_OVL : ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        // Pulse end rules in exposure mode, the row count otherwise
        if (mode_q == rsts_pkg::MODE_EXT_EXP ? fall : exp_hit) begin
          st_d     = ST_SIGNAL;
          ro_start = 1'b1;
        end
      end
      ST_SIGNAL: begin
        if (ro_done) begin
          if (mode_q == rsts_pkg::MODE_EXT_START) begin
            st_d = ST_HOLD;
          end else begin
            st_d     = ST_ARMED;
            ro_start = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // One row of clear keeps cycle at exposure plus frame plus row
        if (ro_tick) begin
          st_d     = ST_FLUSH;
          ro_start = 1'b1;
        end
      end
      ST_OVL: begin
        if (rise) begin
          ro_start = 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Stopping acquisition wins over everything else
    if (!en_q) begin
      st_d     = ST_IDLE;
      ro_start = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Exposure latched per sequence; later writes take the next one
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exp_rows_q <= exp_floor;
      exp_cnt_q  <= '0;
    end else if (ro_start && st_d == ST_FLUSH) begin
      exp_rows_q <= (exp_round < exp_floor) ? exp_floor : exp_round;
      exp_cnt_q  <= '0;
    end else if (ro_tick) begin
      exp_cnt_q <= exp_cnt_q + 32'h0000_0001;
    end
  end

  // Sensor controls registered from the next state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gclr_q    <= 1'b1;
      discard_q <= 1'b1;
      ready_q   <= 1'b0;
    end else begin
      gclr_q  <= !(st_d == ST_FLUSH || st_d == ST_EXPOSE
                   || st_d == ST_SIGNAL || st_d == ST_OVL);
      ready_q <= (st_d == ST_ARMED || st_d == ST_OVL);
      if (ro_start) begin
        discard_q <= !(st_d == ST_SIGNAL || st_q == ST_OVL);
      end
    end
  end

  // Overlap indicator drops for a fixed gap at each edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fire_cnt_q <= '0;
    end else if (st_q == ST_OVL && rise) begin
      fire_cnt_q <= rsts_pkg::FIRE_LOW_CLKS;
    end else if (fire_cnt_q != 5'h00) begin
      fire_cnt_q <= fire_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      expind_q <= 1'b0;
    end else if (st_d == ST_OVL) begin
      expind_q <= (fire_cnt_q <= 5'h01) && !(st_q == ST_OVL && rise);
    end else begin
      expind_q <= (st_d == ST_FLUSH || st_d == ST_EXPOSE);
    end
  end

  assign sensor              = {gclr_q, ro_busy, discard_q};
  assign ready_for_trigger   = ready_q;
  assign exposure_ind        = expind_q;

  // Register writes; mode is frozen unless acquisition is stopped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q                 <= 1'b0;
      mode_q               <= rsts_pkg::MODE_EXT_SW;
      exp_q                <= rsts_pkg::EXP_RST;
      region_of_interest_q <= rsts_pkg::ROI_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        rsts_pkg::A_CTRL: begin
          en_q <= reg_req.wdata[rsts_pkg::CTRL_EN];
          if (st_q == ST_IDLE) begin
            mode_q <= rsts_pkg::rsts_mode_e'(
                        reg_req.wdata[rsts_pkg::CTRL_MODE +: 2]);
          end
        end
        rsts_pkg::A_EXP: begin
          exp_q <= reg_req.wdata;
        end
        rsts_pkg::A_ROI: begin
          // Zero rows would wrap the row count and run a readout of 4096 rows
          if (reg_req.wdata[ROI_W-1:0] != '0) begin
            region_of_interest_q <= reg_req.wdata[ROI_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Completed signal frames outside overlap mode, wrapping
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fcnt_q <= '0;
    end else if (st_q == ST_SIGNAL && ro_done) begin
      fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  // Read data stand one cycle, zero otherwise and when unmapped
  always_ff @(posedge mclk) begin
    if (sys_rst || !reg_req.rd) begin
      rdata_q <= '0;
    end else begin
      case (reg_req.addr)
        rsts_pkg::A_CTRL: rdata_q <= {29'h0000_0000, mode_q, en_q};
        rsts_pkg::A_EXP:  rdata_q <= exp_q;
        rsts_pkg::A_ROI:  rdata_q <= 32'(region_of_interest_q);
        rsts_pkg::A_STAT: rdata_q <= {24'h00_0000, expind_q, ro_busy,
                                      gclr_q, ready_q, 1'b0, st_q};
        rsts_pkg::A_FCNT: rdata_q <= {16'h0000, fcnt_q};
        default:          rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // Helper: consecutive low cycles of the indicator
  always_ff @(posedge mclk) begin
    if (sys_rst || expind_q) begin
      low_run_q <= '0;
    end else if (low_run_q != 8'hFF) begin
      low_run_q <= low_run_q + 8'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence sig_done_s;
    st_q == ST_SIGNAL && ro_done && en_q
      && mode_q != rsts_pkg::MODE_EXT_START;
  endsequence

  sequence armed_edge_s;
    st_q == ST_ARMED && en_q && rise;
  endsequence

  chk_armed_clear: assert property (
    st_q == ST_ARMED |-> sensor.global_clear)
    else $error("clear not held while armed");
  chk_ready_armed: assert property (
    st_q == ST_ARMED |-> ready_for_trigger)
    else $error("ready low while armed");
  chk_sw_start: assert property (
    (st_q == ST_ARMED && en_q && sw_trig
     && mode_q == rsts_pkg::MODE_EXT_SW)
    |=> st_q == ST_FLUSH && sensor.discard && sensor.readout)
    else $error("software trigger did not start flush");
  chk_flush_clear: assert property (
    armed_edge_s |=> !sensor.global_clear && sensor.discard
                     && sensor.readout)
    else $error("flush not started with clear low");
  chk_signal_close: assert property (
    sig_done_s |=> st_q == ST_ARMED && sensor.global_clear
                   ##1 sensor.global_clear)
    else $error("clear not restored after signal frame");
  chk_exp_floor: assert property (
    st_q == ST_EXPOSE |-> exp_rows_q > 32'(region_of_interest_q))
    else $error("exposure below frame plus row");
  chk_sync_edge: assert property (
    $rose(external_trigger_in) ##1 external_trigger_in
    |-> ##1 $rose(trig_s_q))
    else $error("trigger edge not seen two clocks later");
  chk_trig_catch: assert property (
    armed_edge_s |=> st_q == ST_FLUSH)
    else $error("trigger edge missed while armed");
  chk_ext_exp_end: assert property (
    (st_q == ST_EXPOSE && en_q && fall
     && mode_q == rsts_pkg::MODE_EXT_EXP)
    |=> st_q == ST_SIGNAL && !sensor.discard)
    else $error("falling edge did not start signal");
  chk_fall_ignore: assert property (
    (st_q == ST_FLUSH && fall && !ro_done) |=> st_q == ST_FLUSH)
    else $error("falling edge acted on during flush");
  chk_ovl_edge: assert property (
    (st_q == ST_OVL && en_q && rise)
    |=> sensor.readout && !sensor.discard && !sensor.global_clear)
    else $error("overlap edge did not start signal readout");
  chk_fire_low: assert property (
    ($rose(exposure_ind) && $past(st_q) == ST_OVL)
    |-> low_run_q >= 8'(rsts_pkg::FIRE_LOW_MIN))
    else $error("indicator low gap too short");
  chk_start_hold: assert property (
    (st_q == ST_HOLD && en_q && ro_tick) |=> st_q == ST_FLUSH)
    else $error("free-run restart late");
  chk_exp_count: assert property (
    (st_q == ST_EXPOSE && en_q && exp_hit
     && mode_q != rsts_pkg::MODE_EXT_EXP) |=> st_q == ST_SIGNAL)
    else $error("signal not started at exposure row count");
  chk_mode_lock: assert property (
    st_q != ST_IDLE |=> $stable(mode_q))
    else $error("mode changed during acquisition");
endmodule
`default_nettype wire

// ==== testbench/rsts_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsts_far_side (
  input  wire logic                   mclk,
  input  wire rsts_pkg::rsts_sensor_s sensor,
  output logic                        external_trigger_in,
  output logic [15:0]                 rd_len_q
);
  logic [15:0] cnt_q;

  initial external_trigger_in = 1'b0;

  // Pin held for whole cycles, never narrower than two
  task automatic drive(input logic lvl, input int n);
    external_trigger_in <= lvl;
    repeat (n) @(posedge mclk);
  endtask

  // Length of each signal frame burst; prescans run back to back with it
  always_ff @(posedge mclk) begin
    cnt_q <= (sensor.readout && !sensor.discard) ? cnt_q + 16'h0001 : 16'h0000;
    if (!(sensor.readout && !sensor.discard) && cnt_q != 16'h0000) begin
      rd_len_q <= cnt_q;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_rolling_shutter_trigger_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_rolling_shutter_trigger_sequencer;
  // Short rows and a three-row frame keep the run brief
  localparam int RC  = 8;
  localparam int REGION_OF_INTEREST = 3;

  logic                   mclk;
  logic                   sys_rst;
  rsts_pkg::rsts_bus_s    req;
  logic [31:0]            reg_rdata;
  logic                   trig;
  rsts_pkg::rsts_sensor_s sensor;
  logic                   ready_for_trigger;
  logic                   exposure_ind;
  logic [15:0]            rd_len;
  logic [31:0]            v;
  logic [31:0]            f0;
  int                     fail_count;
  int                     total_checks;
  int                     cyc;

  rsts_seq #(.ROW_CLKS(RC), .ROI_W(rsts_pkg::ROI_W)) DUT (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .reg_req             (req),
    .reg_rdata           (reg_rdata),
    .external_trigger_in (trig),
    .sensor              (sensor),
    .ready_for_trigger   (ready_for_trigger),
    .exposure_ind        (exposure_ind)
  );

  rsts_far_side src (
    .mclk                (mclk),
    .sensor              (sensor),
    .external_trigger_in (trig),
    .rd_len_q            (rd_len)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, well above the expected thousand or so cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  task results;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task ok(input string nm, input logic c);
    chk(nm, 32'h0000_0001, {31'h0, c});
  endtask

  // Let the edge's updates land before looking
  task step;
    @(posedge mclk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 d = reg_rdata;
  endtask

  // Mode bits land only from idle, so stop first
  task set_mode(input logic [1:0] m);
    wr(rsts_pkg::A_CTRL, 32'h0);
    wr(rsts_pkg::A_CTRL, {29'h0, m, 1'b1});
  endtask

  task wait_armed;
    int n;
    n = 0;
    while (!(ready_for_trigger === 1'b1 && sensor.global_clear === 1'b1) && n < 300) begin
      step();
      n++;
    end
    ok("armed", n < 300);
  endtask

  // Cycles until clear drops, bounded
  task wait_clr(output int n);
    n = 0;
    while (sensor.global_clear !== 1'b0 && n < 20) begin
      step();
      n++;
    end
  endtask

  task pulse2;
    src.drive(1'b1, 2);
    src.drive(1'b0, 0);
  endtask

  task t_reset;
    rd(rsts_pkg::A_STAT, v);
    chk("status", 32'h0000_0020, v);
    rd(rsts_pkg::A_EXP, v);
    chk("exp", rsts_pkg::EXP_RST, v);
    rd(rsts_pkg::A_ROI, v);
    chk("roi", {20'h0, rsts_pkg::ROI_RST}, v);
    rd(8'h18, v);
    chk("unmapped", 32'h0, v);
    wr(rsts_pkg::A_ROI, 32'h0);
    rd(rsts_pkg::A_ROI, v);
    chk("roi zero", {20'h0, rsts_pkg::ROI_RST}, v);
    wr(rsts_pkg::A_ROI, REGION_OF_INTEREST);
    rd(rsts_pkg::A_ROI, v);
    chk("roi set", REGION_OF_INTEREST, v);
  endtask

  // Software trigger, exposure in half rows, rounded and clamped
  task t_sw(input logic [31:0] e, input int rows);
    int n;
    logic g;
    wr(rsts_pkg::A_EXP, e);
    wait_armed();
    n = 0;
    while (sensor.readout !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    chk("prescan", 3'b111, {sensor.global_clear, sensor.discard, ready_for_trigger});
    rd(rsts_pkg::A_FCNT, f0);
    wr(rsts_pkg::A_SWTRIG, 32'h0000_0001);
    chk("flush", 5'b01101, {sensor.global_clear, sensor.readout, sensor.discard, ready_for_trigger,
                            exposure_ind});
    n = 0;
    g = 1'b0;
    while (sensor.discard !== 1'b0 && n < 400) begin
      step();
      n++;
      g = g | sensor.global_clear;
    end
    ok("exposure", n >= rows * RC - 1 && n <= rows * RC + 1);
    chk("clear low", 32'h0, {31'h0, g});
    n = 0;
    while (sensor.discard !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    step();
    chk("signal len", REGION_OF_INTEREST * RC, {16'h0, rd_len});
    chk("hold clear", 2'b11, {sensor.global_clear, ready_for_trigger});
    rd(rsts_pkg::A_FCNT, v);
    chk("fcnt", f0 + 32'h1, v);
  endtask

  task t_pin;
    int n;
    wait_armed();
    pulse2();
    wait_clr(n);
    ok("pin start", n <= RC);
    ok("pin flush", sensor.readout === 1'b1 && sensor.discard === 1'b1);
  endtask

  task t_exp;
    int n;
    set_mode(2'h1);
    wait_armed();
    src.drive(1'b1, 10);
    src.drive(1'b0, 30);
    rd(rsts_pkg::A_STAT, v);
    chk("still exposing", 3'h3, v[2:0]);
    src.drive(1'b1, 5);
    src.drive(1'b0, 0);
    n = 0;
    while (!(sensor.readout === 1'b1 && sensor.discard === 1'b0) && n < 10) begin
      step();
      n++;
    end
    ok("fall starts signal", n <= 5);
  endtask

  task t_ovl;
    int n;
    int lo;
    int mx;
    logic g;
    logic s;
    set_mode(2'h2);
    wait_armed();
    pulse2();
    wait_clr(n);
    ok("ovl discard", n <= RC && sensor.discard === 1'b1);
    src.drive(1'b0, 50);
    ok("ovl ready", ready_for_trigger === 1'b1);
    pulse2();
    lo = 0;
    mx = 0;
    g = 1'b0;
    s = 1'b0;
    for (n = 0; n < 40; n++) begin
      step();
      lo = exposure_ind ? 0 : lo + 1;
      if (lo > mx) mx = lo;
      g = g | sensor.global_clear;
      s = s | (sensor.readout & ~sensor.discard);
    end
    ok("ovl signal", s === 1'b1 && g === 1'b0);
    ok("fire low", mx >= rsts_pkg::FIRE_LOW_MIN);
  endtask

  task t_start;
    int n;
    set_mode(2'h3);
    wait_armed();
    rd(rsts_pkg::A_FCNT, f0);
    pulse2();
    wait_clr(n);
    ok("start delay", n <= RC);
    repeat (600) step();
    rd(rsts_pkg::A_FCNT, v);
    ok("free run", v >= f0 + 32'h2);
    wr(rsts_pkg::A_CTRL, 32'h0);
    rd(rsts_pkg::A_STAT, v);
    chk("stopped", 4'h8, {v[5], v[2:0]});
  endtask

  initial begin
    req = '0;
    sys_rst = 1'b1;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    set_mode(2'h0);
    wr(rsts_pkg::A_CTRL, 32'h0000_0003);
    rd(rsts_pkg::A_CTRL, v);
    chk("mode lock", 32'h0000_0001, v);
    t_sw(32'h0000_0009, 5);
    t_sw(32'h0000_0002, REGION_OF_INTEREST + 1);
    t_pin();
    t_exp();
    t_ovl();
    t_start();
    results();
  end
endmodule
`default_nettype wire
